// ---- common/ftm_defines.svh ----
// Shared constants of the fan tachometer monitor
`ifndef FTM_DEFINES_SVH
`define FTM_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define FTM_CLK_HZ 10000000
`define FTM_REF_HZ 32768
`define FTM_INT_DIV (`FTM_CLK_HZ / `FTM_REF_HZ)

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define FTM_A_FANCTL 8'h58
`define FTM_A_PRE1 8'h60
`define FTM_A_PRE2 8'h64
`define FTM_A_CNT1 8'h68
`define FTM_A_CNT2 8'h6C
`define FTM_A_WAKE 8'h70
`define FTM_A_CLK 8'h74
`define FTM_A_STAT 8'h78
`define FTM_A_MGMT 8'h7C

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FTM_FANCTL_RST 8'h50
`define FTM_DIV1_LSB 4
`define FTM_DIV2_LSB 6
`define FTM_CNT_MAX 8'hFF
`define FTM_SLOW_CNT 8'hC0
`define FTM_RESP_OKAY 2'h0
`define FTM_RESP_SLVERR 2'h2

`endif

// ---- common/ftm_pkg.sv ----
// Types of the fan tachometer monitor
package ftm_pkg;
	typedef enum {
		FTM_R_FANCTL,
		FTM_R_PRE1,
		FTM_R_PRE2,
		FTM_R_CNT1,
		FTM_R_CNT2,
		FTM_R_WAKE,
		FTM_R_MGMT,
		FTM_R_CLK,
		FTM_R_STAT,
		FTM_R_NONE
	} ftm_reg_t;
	typedef logic [1:0] ftm_div_t;
	typedef logic [7:0] ftm_cnt_t;
endpackage : ftm_pkg

// ---- common/ftm_chan_if.sv ----
// Link between the register file and one tachometer channel
interface ftm_chan_if;
	logic ref_tick;
	ftm_pkg::ftm_div_t div_code;
	ftm_pkg::ftm_cnt_t preload;
	logic preload_wr;
	ftm_pkg::ftm_cnt_t count;
	logic slow;
	modport ctrl (output ref_tick, output div_code, output preload, output preload_wr,
		input count, input slow);
	modport chan (input ref_tick, input div_code, input preload, input preload_wr,
		output count, output slow);
endinterface : ftm_chan_if

// ---- design/ftm_ref_gen.sv ----
// Count reference tick: external slow clock edges or internal divider
`include "ftm_defines.svh"
module ftm_ref_gen #(
	parameter int INT_DIV = `FTM_INT_DIV
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Source select and external clock
	input wire logic ext_sel,
	input wire logic ext_slow_clock_in,
	// Reference enable pulse
	output logic ref_tick
);
	import ftm_pkg::*;
	localparam int CW = $clog2(INT_DIV);
	logic [2:0] sync;
	logic [2:0] next_sync;
	logic lvl;
	logic next_lvl;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic next_tick;

	always_comb begin
		next_sync = {sync[1:0], ext_slow_clock_in};
		next_lvl = lvl;
		next_cnt = cnt;
		next_tick = 1'b0;
		// Level only moves once the last two stages agree
		if (sync[1] == sync[2]) begin
			next_lvl = sync[1];
		end
		if (ext_sel) begin
			next_cnt = '0;
			next_tick = sync[1] & sync[2] & ~lvl; // [R3]
		end else if (cnt == CW'(INT_DIV - 1)) begin
			next_cnt = '0;
			next_tick = 1'b1; // [R3]
		end else begin
			next_cnt = cnt + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync <= 3'h0;
			lvl <= 1'b0;
			cnt <= '0;
			ref_tick <= 1'b0;
		end else begin
			sync <= next_sync;
			lvl <= next_lvl;
			cnt <= next_cnt;
			ref_tick <= next_tick;
		end
	end

	chk_int_period: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
		(!ext_sel && $past(!ext_sel) && ref_tick) |=> !ref_tick [*8])
		else $error("internal reference ticks too often");
	chk_ext_source: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
		(ext_sel && $past(ext_sel) && ref_tick) |-> (lvl && !$past(lvl)))
		else $error("external reference tick without clock edge");
endmodule : ftm_ref_gen

// ---- design/ftm_tach_chan.sv ----
// One tachometer channel: edge detect, divider, saturating counter
`include "ftm_defines.svh"
module ftm_tach_chan (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Fan tachometer pin
	input wire logic tach_in,
	// Register side
	ftm_chan_if.chan ch
);
	import ftm_pkg::*;
	logic [2:0] sync;
	logic [2:0] next_sync;
	logic lvl;
	logic next_lvl;
	logic rise;
	logic restart;
	logic div_tick;
	logic [2:0] mask;
	logic [2:0] div;
	logic [2:0] next_div;
	ftm_cnt_t count;
	ftm_cnt_t next_count;
	logic slow;
	logic next_slow;

	function automatic logic [2:0] div_mask(input ftm_div_t code);
		case (code)
			2'h0: div_mask = 3'h0;
			2'h1: div_mask = 3'h1;
			2'h2: div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	endfunction : div_mask

	always_comb begin
		next_sync = {sync[1:0], tach_in}; // [R12]
		next_lvl = lvl;
		if (sync[1] == sync[2]) begin
			next_lvl = sync[1];
		end
		rise = sync[1] & sync[2] & ~lvl;
		restart = rise | ch.preload_wr; // [R4]
		mask = div_mask(ch.div_code); // [R9] [R13]
		next_div = div;
		div_tick = 1'b0;
		// Divider restarts with the count so each period starts in phase
		if (restart) begin
			next_div = 3'h0;
		end else if (ch.ref_tick) begin
			if ((div & mask) == mask) begin
				div_tick = 1'b1;
				next_div = 3'h0;
			end else begin
				next_div = div + 3'h1;
			end
		end
		next_count = count;
		if (restart) begin
			next_count = ch.preload; // [R8]
		end else if (div_tick && count != `FTM_CNT_MAX) begin
			next_count = count + 8'h01; // [R2] [R5]
		end
		// Mask with the threshold so only the two top bits are looked at
		next_slow = ((next_count & `FTM_SLOW_CNT) == `FTM_SLOW_CNT); // [R6]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync <= 3'h0;
			lvl <= 1'b0;
			div <= 3'h0;
			count <= 8'h00;
			slow <= 1'b0;
		end else begin
			sync <= next_sync;
			lvl <= next_lvl;
			div <= next_div;
			count <= next_count;
			slow <= next_slow;
		end
	end

	assign ch.count = count;
	assign ch.slow = slow;

	chk_restart_load: assert property (@(posedge aclk) disable iff (!aresetn) // [R4] [R8]
		restart |=> (count == $past(ch.preload)))
		else $error("counter not loaded from preload");
	chk_sat_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
		(count == `FTM_CNT_MAX && !restart) |=> (count == `FTM_CNT_MAX))
		else $error("counter left full scale without restart");
	chk_inc_step: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		(div_tick && !restart && count != `FTM_CNT_MAX) |=> (count == $past(count) + 8'h01))
		else $error("counter missed a step");
	chk_div_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
		(!restart && !div_tick) |=> $stable(count))
		else $error("counter moved without divided tick");
	chk_slow_mark: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
		slow == (count >= `FTM_SLOW_CNT))
		else $error("slow flag disagrees with count");
	cov_saturate: cover property (@(posedge aclk) disable iff (!aresetn)
		count == `FTM_CNT_MAX ##1 restart);
	cov_slow: cover property (@(posedge aclk) disable iff (!aresetn) $rose(slow));
endmodule : ftm_tach_chan

// ---- design/ftm_top.sv ----
// Two-channel fan tachometer monitor with AXI4-Lite registers
// Operation
// R1: Two independent channels, own counter, preload, divisor
// R2: Count divided reference per tach period, 8 bits
// R3: Reference from external clock or internal divider
// R4: Tach rising edge or preload write resets counter
// R5: Counter saturates at full scale until reset
// R6: Both top count bits set flag slow fan
// R7: Slow fan raises wake/management event when enabled
// R8: Counter restarts from programmed preload value
// R9: Divisor 1, 2, 4 or 8, default 2
// R10: Divisor settings in fan control register
// R11: Two-bit divisor fields at bits 7:6, 5:4
// R12: Tach synchronised; read data latched for access
// R13: Divisor codes binary ascending, default code 01
//
// Implementation choice: the AXI4-Lite slave port.
`include "ftm_defines.svh"
module ftm_top #(
	parameter int ADDR_W = 8,
	parameter int INT_DIV = `FTM_INT_DIV
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Fan pins
	input wire logic tach_input_one,
	input wire logic tach_input_two,
	input wire logic ext_slow_clock_in,
	// Events
	output logic wake_event,
	output logic mgmt_event
);
	import ftm_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic aw_full;
	logic next_aw_full;
	logic [ADDR_W-1:0] aw_addr;
	logic [ADDR_W-1:0] next_aw_addr;
	logic w_full;
	logic next_w_full;
	logic [7:0] w_data;
	logic [7:0] next_w_data;
	logic w_lane;
	logic next_w_lane;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [7:0] fan_control;
	logic [7:0] next_fan_control;
	ftm_cnt_t preload [2];
	ftm_cnt_t next_preload [2];
	logic [1:0] pre_wr;
	logic [1:0] next_pre_wr;
	logic [1:0] wake_enable_one;
	logic [1:0] next_wake_enable_one;
	logic [1:0] mgmt_int_enable_five;
	logic [1:0] next_mgmt_int_enable_five;
	logic ext_slow_clock_present;
	logic next_ext_slow_clock_present;
	logic next_wake;
	logic next_mgmt;
	ftm_reg_t wsel;
	ftm_reg_t rsel;
	logic ref_tick;
	logic [1:0] tach;
	logic [1:0] slow;
	ftm_cnt_t count [2];

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic ftm_reg_t reg_sel(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'(`FTM_A_FANCTL)) begin
			reg_sel = FTM_R_FANCTL; // [R10]
		end else if (a == ADDR_W'(`FTM_A_PRE1)) begin
			reg_sel = FTM_R_PRE1;
		end else if (a == ADDR_W'(`FTM_A_PRE2)) begin
			reg_sel = FTM_R_PRE2;
		end else if (a == ADDR_W'(`FTM_A_CNT1)) begin
			reg_sel = FTM_R_CNT1;
		end else if (a == ADDR_W'(`FTM_A_CNT2)) begin
			reg_sel = FTM_R_CNT2;
		end else if (a == ADDR_W'(`FTM_A_WAKE)) begin
			reg_sel = FTM_R_WAKE;
		end else if (a == ADDR_W'(`FTM_A_MGMT)) begin
			reg_sel = FTM_R_MGMT;
		end else if (a == ADDR_W'(`FTM_A_CLK)) begin
			reg_sel = FTM_R_CLK;
		end else if (a == ADDR_W'(`FTM_A_STAT)) begin
			reg_sel = FTM_R_STAT;
		end else begin
			reg_sel = FTM_R_NONE;
		end
	endfunction : reg_sel

	// ----------------------------------------
	// Write channel and register file
	// ----------------------------------------
	always_comb begin
		next_aw_full = aw_full;
		next_aw_addr = aw_addr;
		next_w_full = w_full;
		next_w_data = w_data;
		next_w_lane = w_lane;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_fan_control = fan_control;
		next_preload = preload;
		next_pre_wr = 2'h0;
		next_wake_enable_one = wake_enable_one;
		next_mgmt_int_enable_five = mgmt_int_enable_five;
		next_ext_slow_clock_present = ext_slow_clock_present;
		wsel = reg_sel(aw_addr);
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_full = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata[7:0];
			next_w_lane = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_full && w_full && !s_axi_bvalid) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (wsel == FTM_R_NONE) ? `FTM_RESP_SLVERR : `FTM_RESP_OKAY;
			// Only byte lane 0 carries register bits
			if (w_lane) begin
				case (wsel)
					FTM_R_FANCTL: next_fan_control = w_data;
					FTM_R_PRE1: begin
						next_preload[0] = w_data;
						next_pre_wr[0] = 1'b1; // [R4]
					end
					FTM_R_PRE2: begin
						next_preload[1] = w_data;
						next_pre_wr[1] = 1'b1; // [R4]
					end
					FTM_R_WAKE: next_wake_enable_one = w_data[1:0];
					FTM_R_MGMT: next_mgmt_int_enable_five = w_data[1:0];
					FTM_R_CLK: next_ext_slow_clock_present = w_data[0];
					default: next_bresp = next_bresp;
				endcase
			end
		end
		next_awready = !next_aw_full && !next_bvalid;
		next_wready = !next_w_full && !next_bvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			aw_addr <= '0;
			w_full <= 1'b0;
			w_data <= 8'h00;
			w_lane <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FTM_RESP_OKAY;
			fan_control <= `FTM_FANCTL_RST; // [R9] [R13]
			preload <= '{8'h00, 8'h00};
			pre_wr <= 2'h0;
			wake_enable_one <= 2'h0;
			mgmt_int_enable_five <= 2'h0;
			ext_slow_clock_present <= 1'b0;
		end else begin
			aw_full <= next_aw_full;
			aw_addr <= next_aw_addr;
			w_full <= next_w_full;
			w_data <= next_w_data;
			w_lane <= next_w_lane;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			fan_control <= next_fan_control;
			preload <= next_preload;
			pre_wr <= next_pre_wr;
			wake_enable_one <= next_wake_enable_one;
			mgmt_int_enable_five <= next_mgmt_int_enable_five;
			ext_slow_clock_present <= next_ext_slow_clock_present;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	// Data is captured at the address handshake and held until taken,
	// so a count that moves meanwhile cannot tear the answer
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		rsel = reg_sel(s_axi_araddr);
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata = 32'h0000_0000;
			next_rresp = `FTM_RESP_OKAY;
			case (rsel)
				FTM_R_FANCTL: next_rdata[7:0] = fan_control;
				FTM_R_PRE1: next_rdata[7:0] = preload[0];
				FTM_R_PRE2: next_rdata[7:0] = preload[1];
				FTM_R_CNT1: next_rdata[7:0] = count[0]; // [R12]
				FTM_R_CNT2: next_rdata[7:0] = count[1]; // [R12]
				FTM_R_WAKE: next_rdata[1:0] = wake_enable_one;
				FTM_R_MGMT: next_rdata[1:0] = mgmt_int_enable_five;
				FTM_R_CLK: next_rdata[0] = ext_slow_clock_present;
				FTM_R_STAT: next_rdata[1:0] = slow;
				default: next_rresp = `FTM_RESP_SLVERR;
			endcase
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `FTM_RESP_OKAY;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	ftm_ref_gen #(
		.INT_DIV(INT_DIV)
	) u_ref (
		.aclk(aclk),
		.aresetn(aresetn),
		.ext_sel(ext_slow_clock_present), // [R3]
		.ext_slow_clock_in(ext_slow_clock_in),
		.ref_tick(ref_tick)
	);

	assign tach = {tach_input_two, tach_input_one};
	ftm_chan_if ch [2] ();

	for (genvar i = 0; i < 2; i++) begin : g_ch
		// Each channel has its own divisor field, preload and counter
		localparam int LSB = (i == 0) ? `FTM_DIV1_LSB : `FTM_DIV2_LSB;
		assign ch[i].ref_tick = ref_tick;
		assign ch[i].div_code = fan_control[LSB+1:LSB]; // [R11]
		assign ch[i].preload = preload[i];
		assign ch[i].preload_wr = pre_wr[i];
		assign count[i] = ch[i].count;
		assign slow[i] = ch[i].slow;
		ftm_tach_chan u_chan ( // [R1]
			.aclk(aclk),
			.aresetn(aresetn),
			.tach_in(tach[i]),
			.ch(ch[i])
		);
	end

	// ----------------------------------------
	// Events
	// ----------------------------------------
	always_comb begin
		next_wake = |(slow & wake_enable_one); // [R7]
		next_mgmt = |(slow & mgmt_int_enable_five); // [R7]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_event <= 1'b0;
			mgmt_event <= 1'b0;
		end else begin
			wake_event <= next_wake;
			mgmt_event <= next_mgmt;
		end
	end

	chk_wake_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		##1 wake_event == $past(|(slow & wake_enable_one)))
		else $error("wake event does not follow enabled slow flag");
	chk_mgmt_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		##1 mgmt_event == $past(|(slow & mgmt_int_enable_five)))
		else $error("management event does not follow enabled slow flag");
	chk_preload_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
		(aw_full && w_full && !s_axi_bvalid && w_lane && wsel == FTM_R_PRE1)
		|=> (pre_wr[0] && s_axi_bvalid) ##1 !pre_wr[0])
		else $error("preload write did not restart channel once");
	chk_read_stable: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
		(s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
		else $error("read data changed before taken");
	chk_fanctl_default: assert property (@(posedge aclk) disable iff (!aresetn) // [R9] [R13]
		$past(!aresetn) |-> (fan_control == `FTM_FANCTL_RST))
		else $error("divisor fields not at default after reset");
	cov_wake: cover property (@(posedge aclk) disable iff (!aresetn) $rose(wake_event));
	cov_cnt_read: cover property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && rsel == FTM_R_CNT1);
	cov_mgmt: cover property (@(posedge aclk) disable iff (!aresetn) $rose(mgmt_event));
endmodule : ftm_top

// ---- tb/ftm_fan_model.sv ----
// Behavioural cooling fan driving one tachometer pin
module ftm_fan_model (
	// Clock
	input wire logic aclk,
	// Pulse period in clock cycles, 0 stops the fan
	input wire logic [15:0] period,
	// Tachometer pin
	output logic tach
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] pos = 16'h0000;
	// ----------------------------------------
	// Pulse train
	// ----------------------------------------
	// A stopped fan parks its pin low; restarting begins with a rising edge
	always @(posedge aclk) begin
		if (period == 16'h0000) begin
			pos <= 16'h0000;
			tach <= 1'b0;
		end else begin
			pos <= (pos + 16'h0001 >= period) ? 16'h0000 : pos + 16'h0001;
			tach <= (pos < 16'h0004);
		end
	end
endmodule : ftm_fan_model

// ---- tb/tb_top.sv ----
// Self-checking bench of the fan tachometer monitor
`include "ftm_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DIV = 10;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic tach_input_one;
	logic tach_input_two;
	logic ext_slow_clock_in = 1'b0;
	logic wake_event;
	logic mgmt_event;
	logic [15:0] per_one = 16'h0000;
	logic [15:0] per_two = 16'h0000;
	logic ext_run = 1'b0;
	logic [3:0] ext_cnt = 4'h0;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	ftm_top #(.ADDR_W(8), .INT_DIV(DIV)) u_ftm_top (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.tach_input_one(tach_input_one), .tach_input_two(tach_input_two),
		.ext_slow_clock_in(ext_slow_clock_in),
		.wake_event(wake_event), .mgmt_event(mgmt_event)
	);
	ftm_fan_model u_ftm_fan_model_one (.aclk(aclk), .period(per_one), .tach(tach_input_one));
	ftm_fan_model u_ftm_fan_model_two (.aclk(aclk), .period(per_two), .tach(tach_input_two));
	// ----------------------------------------
	// Clock, external slow clock, watchdog
	// ----------------------------------------
	always #50 aclk = ~aclk;
	// Slow clock is scaled to 20 cycles a period and stands still when not running
	always @(posedge aclk) begin
		if (ext_run) begin
			ext_cnt <= (ext_cnt == 4'h9) ? 4'h0 : ext_cnt + 4'h1;
			if (ext_cnt == 4'h9) begin
				ext_slow_clock_in <= ~ext_slow_clock_in;
			end
		end
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : check_val
	task automatic check_rng(input string nm, input logic [7:0] lo, input logic [7:0] hi,
		input logic [31:0] got);
		n_tests++;
		if ($isunknown(got) || got < 32'(lo) || got > 32'(hi)) begin
			err_total++;
			$display("wrong value %s expected %h to %h seen %h", nm, lo, hi, got);
		end
	endtask : check_rng
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
		logic [1:0] r;
		wr(a, d, r);
		check_val("bresp", 32'(exp), 32'(r));
	endtask : wr_chk
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		check_val("rdata", exp, d);
		check_val("rresp", 32'(er), 32'(r));
	endtask : rd_chk
	task automatic rd_rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		check_rng("count", lo, hi, d);
	endtask : rd_rng
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_map();
		rd_chk(`FTM_A_FANCTL, 32'h50, `FTM_RESP_OKAY);
		rd_chk(`FTM_A_CNT1, 32'h0, `FTM_RESP_OKAY);
		rd_chk(`FTM_A_STAT, 32'h0, `FTM_RESP_OKAY);
		wr_chk(`FTM_A_FANCTL, 32'hA7, `FTM_RESP_OKAY);
		rd_chk(`FTM_A_FANCTL, 32'hA7, `FTM_RESP_OKAY);
		wr_chk(8'h40, 32'h5, `FTM_RESP_SLVERR);
		rd_chk(8'h40, 32'h0, `FTM_RESP_SLVERR);
	endtask : t_reset_map
	task automatic t_preload();
		// Divide by 8 keeps the counters still while the bus settles
		wr_chk(`FTM_A_FANCTL, 32'hF0, `FTM_RESP_OKAY);
		wr_chk(`FTM_A_PRE1, 32'h33, `FTM_RESP_OKAY);
		rd_chk(`FTM_A_CNT1, 32'h33, `FTM_RESP_OKAY);
		wr_chk(`FTM_A_PRE2, 32'h44, `FTM_RESP_OKAY);
		rd_chk(`FTM_A_CNT2, 32'h44, `FTM_RESP_OKAY);
		wr_chk(`FTM_A_CNT1, 32'h99, `FTM_RESP_OKAY);
		// A write with lane 0 disabled must leave the preload alone
		s_axi_wstrb <= 4'h0;
		wr_chk(`FTM_A_PRE1, 32'h77, `FTM_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd_chk(`FTM_A_PRE1, 32'h33, `FTM_RESP_OKAY);
		rd_chk(`FTM_A_CNT1, 32'h33, `FTM_RESP_OKAY);
	endtask : t_preload
	task automatic t_divisors();
		for (int c = 0; c < 4; c++) begin
			wr_chk(`FTM_A_FANCTL, 32'(((3 - c) << `FTM_DIV2_LSB) | (c << `FTM_DIV1_LSB)),
				`FTM_RESP_OKAY);
			wr_chk(`FTM_A_PRE1, 32'h10, `FTM_RESP_OKAY);
			wr_chk(`FTM_A_PRE2, 32'h10, `FTM_RESP_OKAY);
			per_one <= 16'h03E8;
			per_two <= 16'h03E8;
			@(posedge tach_input_one);
			repeat (900) @(posedge aclk);
			// About 90 reference ticks pass between the tach edge and the read
			rd_rng(`FTM_A_CNT1, 8'(16 + (88 >> c)), 8'(16 + (92 >> c)));
			rd_rng(`FTM_A_CNT2, 8'(16 + (88 >> (3 - c))), 8'(16 + (92 >> (3 - c))));
			per_one <= 16'h0000;
			per_two <= 16'h0000;
		end
	endtask : t_divisors
	task automatic t_saturate();
		wr_chk(`FTM_A_FANCTL, 32'hC0, `FTM_RESP_OKAY);
		wr_chk(`FTM_A_PRE2, 32'h0, `FTM_RESP_OKAY);
		wr_chk(`FTM_A_PRE1, 32'hBE, `FTM_RESP_OKAY);
		rd_chk(`FTM_A_STAT, 32'h0, `FTM_RESP_OKAY);
		repeat (30) @(posedge aclk);
		rd_chk(`FTM_A_STAT, 32'h1, `FTM_RESP_OKAY);
		check_val("wake", 32'h0, 32'(wake_event));
		wr_chk(`FTM_A_WAKE, 32'h1, `FTM_RESP_OKAY);
		repeat (3) @(posedge aclk);
		check_val("wake", 32'h1, 32'(wake_event));
		check_val("mgmt", 32'h0, 32'(mgmt_event));
		wr_chk(`FTM_A_MGMT, 32'h2, `FTM_RESP_OKAY);
		repeat (3) @(posedge aclk);
		check_val("mgmt", 32'h0, 32'(mgmt_event));
		wr_chk(`FTM_A_MGMT, 32'h3, `FTM_RESP_OKAY);
		repeat (3) @(posedge aclk);
		check_val("mgmt", 32'h1, 32'(mgmt_event));
		repeat (700) @(posedge aclk);
		rd_chk(`FTM_A_CNT1, 32'hFF, `FTM_RESP_OKAY);
		repeat (300) @(posedge aclk);
		rd_chk(`FTM_A_CNT1, 32'hFF, `FTM_RESP_OKAY);
		per_one <= 16'h0BB8;
		@(posedge tach_input_one);
		repeat (8) @(posedge aclk);
		rd_rng(`FTM_A_CNT1, 8'hBE, 8'hBF);
		per_one <= 16'h0000;
		wr_chk(`FTM_A_WAKE, 32'h0, `FTM_RESP_OKAY);
		wr_chk(`FTM_A_MGMT, 32'h0, `FTM_RESP_OKAY);
		repeat (3) @(posedge aclk);
		check_val("events", 32'h0, 32'({wake_event, mgmt_event}));
	endtask : t_saturate
	task automatic t_ext_clock();
		wr_chk(`FTM_A_FANCTL, 32'h0, `FTM_RESP_OKAY);
		wr_chk(`FTM_A_CLK, 32'h1, `FTM_RESP_OKAY);
		wr_chk(`FTM_A_PRE1, 32'h10, `FTM_RESP_OKAY);
		repeat (300) @(posedge aclk);
		rd_chk(`FTM_A_CNT1, 32'h10, `FTM_RESP_OKAY);
		ext_run <= 1'b1;
		repeat (400) @(posedge aclk);
		rd_rng(`FTM_A_CNT1, 8'h23, 8'h25);
		ext_run <= 1'b0;
		wr_chk(`FTM_A_CLK, 32'h0, `FTM_RESP_OKAY);
	endtask : t_ext_clock
	task automatic tally_and_finish();
		if (err_total == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset_map();
		t_preload();
		t_divisors();
		t_saturate();
		t_ext_clock();
		tally_and_finish();
	end
endmodule : tb_top
